//--- rtl/vds_pkg.sv
// constants shared by the vector double shift unit, its register-file model and the testbench
// assumes one 25 MHz clock and a 16-bit instruction parcel: op[15:9] i[8:6] j[5:3] k[2:0]
package vds_pkg;
    localparam int CLK_PERIOD_NS = 40;

    localparam int ELEM_W = 64;
    localparam int WIDE_W = 128;
    localparam int CNT_W = 24;
    localparam int VL_W = 7;
    localparam int IDX_W = 6;
    localparam int SEL_W = 3;
    localparam int INSTR_W = 16;
    localparam int TMR_W = 8;

    // instruction parcel fields
    localparam int OP_LSB = 9;
    localparam int OP_W = 7;
    localparam int DEST_LSB = 6;
    localparam int SRC_LSB = 3;
    localparam int CNTSEL_LSB = 0;

    // opcodes, octal 150..153
    localparam logic [6:0] OP_SHL_SINGLE = 7'h68;
    localparam logic [6:0] OP_SHR_SINGLE = 7'h69;
    localparam logic [6:0] OP_SHL_DOUBLE = 7'h6A;
    localparam logic [6:0] OP_SHR_DOUBLE = 7'h6B;
    localparam int OP_DIR_BIT = 0;
    localparam int OP_DBL_BIT = 1;

    localparam logic [CNT_W-1:0] CNT_IMPLIED = 24'h000001;

    // timing, in clock periods
    localparam int ISSUE_CP = 1;
    localparam int VL_SHORT_MAX = 5;
    localparam int DEST_SHORT_CP = 11;
    localparam int DEST_ADD_CP = 6;
    localparam int SRC_SHORT_CP = 5;
    localparam int BUSY_ADD_CP = 4;
    localparam int CHAIN_CP = 6;

    localparam logic [TMR_W-1:0] DEST_SHORT_CYC = TMR_W'(DEST_SHORT_CP);
    localparam logic [TMR_W-1:0] DEST_ADD_CYC = TMR_W'(DEST_ADD_CP);
    localparam logic [TMR_W-1:0] SRC_SHORT_CYC = TMR_W'(SRC_SHORT_CP);
    localparam logic [TMR_W-1:0] BUSY_ADD_CYC = TMR_W'(BUSY_ADD_CP);
    localparam logic [TMR_W-1:0] CHAIN_CYC = TMR_W'(CHAIN_CP);
    localparam logic [TMR_W-1:0] ISSUE_CYC = TMR_W'(ISSUE_CP);
    localparam logic [VL_W-1:0] VL_SHORT_LIM = VL_W'(VL_SHORT_MAX);

    localparam int RES_W = ELEM_W + IDX_W + SEL_W;

    typedef enum logic [0:0] {
        VDS_IDLE = 1'b0,
        VDS_RUN = 1'b1
    } vds_state_t;
endpackage

//--- rtl/vds_fifo.sv
// result buffer: flip-flop FIFO with valid/ready on both sides
// assumes the caller keeps inData stable only for the cycle it is taken
module vds_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("vds_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;

    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem_r[rdPtr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    fifo_no_over_a: assert property (@(posedge clk) disable iff (sys_rst)
        count_r == (AW+1)'(DEPTH) && !pop |=> count_r == (AW+1)'(DEPTH))
        else $error("fifo count moved while full without a pop");
endmodule

//--- rtl/vds_shift_unit.sv
// vector shift unit: single and double (128-bit joined) element shifts
// assumes issue control obeys unitBusy and the reservation holds; source register
// file answers srcRdData for srcRdSel/srcRdIdx in the same cycle as srcRdEn
module vds_shift_unit
    import vds_pkg::*;
#(
    parameter int MAX_VL = 64,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic issueValid,
    input wire logic [INSTR_W-1:0] issueInstr,
    input wire logic [CNT_W-1:0] shiftCountIn,
    input wire logic [VL_W-1:0] vectorLengthIn,
    output logic issueTaken,
    output logic unitBusy,
    output logic srcRdEn,
    output logic [SEL_W-1:0] srcRdSel,
    output logic [IDX_W-1:0] srcRdIdx,
    input wire logic [ELEM_W-1:0] srcRdData,
    output logic srcRelease,
    output logic chainReady,
    output logic destReady,
    output logic resValid,
    input wire logic resReady,
    output logic [SEL_W-1:0] resDest,
    output logic [IDX_W-1:0] resIdx,
    output logic [ELEM_W-1:0] resData
);
    if (MAX_VL < 1 || MAX_VL > (1 << IDX_W)) begin : g_bad_vl
        $error("vds_shift_unit MAX_VL must be 1 to 64");
    end

    // ---- decode
    wire [OP_W-1:0] opField = issueInstr[OP_LSB +: OP_W];
    wire isShiftOp = (opField == OP_SHL_SINGLE) || (opField == OP_SHR_SINGLE)
        || (opField == OP_SHL_DOUBLE) || (opField == OP_SHR_DOUBLE);
    wire [SEL_W-1:0] cntSel = issueInstr[CNTSEL_LSB +: SEL_W];
    wire [CNT_W-1:0] cntPick = (cntSel == '0) ? CNT_IMPLIED : shiftCountIn;
    wire [VL_W-1:0] vlClamp = (vectorLengthIn > VL_W'(MAX_VL)) ? VL_W'(MAX_VL) : vectorLengthIn;

    vds_state_t state_r;
    vds_state_t stateNxt;
    logic unitBusy_r;
    wire issueTake = issueValid && isShiftOp && !unitBusy_r && (state_r == VDS_IDLE);

    // ---- held instruction
    logic dbl_r;
    logic left_r;
    logic [SEL_W-1:0] dest_r;
    logic [SEL_W-1:0] src_r;
    logic [CNT_W-1:0] cnt_r;
    logic [VL_W-1:0] vl_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dbl_r <= 1'b0;
            left_r <= 1'b0;
            dest_r <= '0;
            src_r <= '0;
            cnt_r <= '0;
            vl_r <= '0;
        end else if (issueTake) begin
            dbl_r <= opField[OP_DBL_BIT];
            left_r <= ~opField[OP_DIR_BIT];
            dest_r <= issueInstr[DEST_LSB +: SEL_W];
            src_r <= issueInstr[SRC_LSB +: SEL_W];
            cnt_r <= cntPick;
            vl_r <= vlClamp;
        end
    end

    // ---- element sequencer
    logic [VL_W-1:0] step_r;
    logic [ELEM_W-1:0] prev_r;
    logic srcRdEn_r;
    logic [VL_W-1:0] pushCnt_r;

    wire fifoInReady;
    wire dblLeft = dbl_r && left_r;
    // the left double shift needs one extra step to flush the last element against zeros
    wire [VL_W-1:0] lastStep = dblLeft ? vl_r : vl_r - 1'b1;
    wire running = (state_r == VDS_RUN);
    wire advance = running && fifoInReady;
    wire stepInRange = (step_r < vl_r);
    wire [ELEM_W-1:0] curElem = stepInRange ? srcRdData : '0;
    wire [WIDE_W-1:0] joined = {prev_r, curElem};
    wire [WIDE_W-1:0] joinedShl = joined << cnt_r;
    wire [WIDE_W-1:0] joinedShr = joined >> cnt_r;
    wire [ELEM_W-1:0] singleShl = curElem << cnt_r;
    wire [ELEM_W-1:0] singleShr = curElem >> cnt_r;
    wire [ELEM_W-1:0] dblLeftRes = joinedShl[WIDE_W-1 -: ELEM_W];
    wire [ELEM_W-1:0] dblRightRes = joinedShr[ELEM_W-1:0];
    wire [ELEM_W-1:0] singleRes = left_r ? singleShl : singleShr;
    wire [ELEM_W-1:0] dblRes = left_r ? dblLeftRes : dblRightRes;
    wire [ELEM_W-1:0] resultElem = dbl_r ? dblRes : singleRes;
    // left double writes element step-1; step 0 only loads the upper half
    wire [VL_W-1:0] resIdxWide = dblLeft ? step_r - 1'b1 : step_r;
    wire pushValid = advance && !(dblLeft && step_r == '0);
    wire isLast = (step_r == lastStep);
    wire [VL_W-1:0] stepNxt = issueTake ? '0 : (advance ? step_r + 1'b1 : step_r);
    wire [RES_W-1:0] fifoInData = {dest_r, resIdxWide[IDX_W-1:0], resultElem};

    always_comb begin
        stateNxt = state_r;
        case (state_r)
            VDS_IDLE: begin
                if (issueTake && vlClamp != '0) begin
                    stateNxt = VDS_RUN;
                end
            end
            VDS_RUN: begin
                if (advance && isLast) begin
                    stateNxt = VDS_IDLE;
                end
            end
            default: stateNxt = VDS_IDLE;
        endcase
    end

    wire [VL_W-1:0] vlNext = issueTake ? vlClamp : vl_r;
    wire srcRdEnNxt = (stateNxt == VDS_RUN) && (stepNxt < vlNext);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= VDS_IDLE;
            step_r <= '0;
            srcRdEn_r <= 1'b0;
            pushCnt_r <= '0;
        end else begin
            state_r <= stateNxt;
            step_r <= stepNxt;
            srcRdEn_r <= srcRdEnNxt;
            pushCnt_r <= issueTake ? '0 : pushCnt_r + VL_W'(pushValid);
        end
    end

    // right double starts with zeros above element 0
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= '0;
        end else if (issueTake) begin
            prev_r <= '0;
        end else if (advance) begin
            prev_r <= curElem;
        end
    end

    assign srcRdEn = srcRdEn_r;
    assign srcRdSel = src_r;
    assign srcRdIdx = step_r[IDX_W-1:0];

    // ---- issue timing: counts clock periods from the issue edge
    logic [TMR_W-1:0] tmr_r;
    logic tmrOn_r;
    logic issueTaken_r;
    logic srcRelease_r;
    logic chainReady_r;
    logic destReady_r;

    wire [TMR_W-1:0] vlTm = TMR_W'(vlNext);
    wire vlShort = (vlNext <= VL_SHORT_LIM);
    wire [TMR_W-1:0] destDelay = vlShort ? DEST_SHORT_CYC : vlTm + DEST_ADD_CYC;
    wire [TMR_W-1:0] srcDelay = vlShort ? SRC_SHORT_CYC : vlTm;
    wire [TMR_W-1:0] busyEnd = vlTm + BUSY_ADD_CYC;
    wire [TMR_W-1:0] tmrNxt = issueTake ? ISSUE_CYC : tmr_r + 1'b1;
    wire tmrLive = issueTake || (tmrOn_r && tmr_r < destDelay);
    // busy also covers a result stream stalled by the consumer
    wire busyNxt = issueTake || (tmrOn_r && tmrNxt < busyEnd) || (stateNxt == VDS_RUN);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_r <= '0;
            tmrOn_r <= 1'b0;
            unitBusy_r <= 1'b0;
            issueTaken_r <= 1'b0;
            srcRelease_r <= 1'b0;
            chainReady_r <= 1'b0;
            destReady_r <= 1'b0;
        end else begin
            tmrOn_r <= tmrLive;
            tmr_r <= tmrLive ? tmrNxt : tmr_r;
            unitBusy_r <= busyNxt;
            issueTaken_r <= issueTake;
            srcRelease_r <= tmrLive && (tmrNxt == srcDelay);
            chainReady_r <= tmrLive && (tmrNxt == CHAIN_CYC);
            destReady_r <= tmrLive && (tmrNxt == destDelay);
        end
    end

    assign issueTaken = issueTaken_r;
    assign unitBusy = unitBusy_r;
    assign srcRelease = srcRelease_r;
    assign chainReady = chainReady_r;
    assign destReady = destReady_r;

    // ---- result buffer towards the destination register file
    wire [RES_W-1:0] fifoOutData;

    vds_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(resValid),
        .outReady(resReady),
        .outData(fifoOutData)
    );

    assign resDest = fifoOutData[RES_W-1 -: SEL_W];
    assign resIdx = fifoOutData[ELEM_W +: IDX_W];
    assign resData = fifoOutData[ELEM_W-1:0];

    // ---- checks
    sequence issue_short_s;
        issueTaken_r && vl_r <= VL_SHORT_LIM;
    endsequence

    sequence run_end_s;
        running && advance && isLast;
    endsequence

    dest_ready_short_a: assert property (@(posedge clk) disable iff (sys_rst)
        issue_short_s |-> !destReady_r [*8] ##1 !destReady_r [*2] ##1 destReady_r)
        else $error("destination ready not 11 periods after issue");
    dest_ready_long_a: assert property (@(posedge clk) disable iff (sys_rst)
        destReady_r && vl_r > VL_SHORT_LIM |-> tmr_r == TMR_W'(vl_r) + DEST_ADD_CYC)
        else $error("destination ready not length plus 6 after issue");
    src_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        issue_short_s |-> ##4 srcRelease_r)
        else $error("source not released 5 periods after issue");
    chain_slot_a: assert property (@(posedge clk) disable iff (sys_rst)
        issueTaken_r |-> ##5 chainReady_r ##1 !chainReady_r)
        else $error("chain slot not open 6 periods after issue");
    busy_window_a: assert property (@(posedge clk) disable iff (sys_rst)
        issueTaken_r |-> unitBusy_r [*4])
        else $error("unit not busy after issue");
    op_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        run_end_s |=> pushCnt_r == vl_r)
        else $error("element operation count differs from vector length");
    dest_range_a: assert property (@(posedge clk) disable iff (sys_rst)
        pushValid |-> resIdxWide < vl_r)
        else $error("result written at or past vector length");
    dbl_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        pushValid && dbl_r && cnt_r > 24'h000080 |-> resultElem == '0)
        else $error("double shift over 128 not zero");
    single_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        pushValid && !dbl_r && cnt_r > 24'h00003F |-> resultElem == '0)
        else $error("single shift over 63 not cleared");
    implied_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        issueTaken_r && $past(issueInstr[2:0]) == 3'h0 |-> cnt_r == CNT_IMPLIED)
        else $error("count selector zero did not give count one");
    left_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        running && dblLeft && step_r == '0 |-> !pushValid)
        else $error("left double wrote before joining the second element");
endmodule

//--- dv/vds_vreg_model.sv
// far side of the shift unit: vector register files, source read port and result sink
// assumes one clock; the testbench fills the registers and reads them back directly
module vds_vreg_model
    import vds_pkg::*;
(
    input wire logic clk,
    input wire logic srcRdEn,
    input wire logic [SEL_W-1:0] srcRdSel,
    input wire logic [IDX_W-1:0] srcRdIdx,
    output logic [ELEM_W-1:0] srcRdData,
    input wire logic resValid,
    output logic resReady,
    input wire logic [SEL_W-1:0] resDest,
    input wire logic [IDX_W-1:0] resIdx,
    input wire logic [ELEM_W-1:0] resData,
    input wire logic stallEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ELEM_W-1:0] vreg [0:7][0:63];
    logic [ELEM_W-1:0] lastRd_r = 64'h0;
    logic [5:0] holdCnt_r = 6'h00;
    int popCount = 0;
    // an idle read port shows the inverse of its last word, never a stale copy
    assign srcRdData = srcRdEn ? vreg[srcRdSel][srcRdIdx] : ~lastRd_r;
    // a stalling consumer holds off for 40 edges with a result waiting, so the result buffer fills and refuses
    assign resReady = !stallEn || (holdCnt_r == 6'h28);
    always @(posedge clk) begin
        if (srcRdEn) begin
            lastRd_r <= srcRdData;
        end
        if (!stallEn) begin
            holdCnt_r <= 6'h00;
        end else if (resValid && holdCnt_r != 6'h28) begin
            holdCnt_r <= holdCnt_r + 6'h01;
        end
        // only the popped element is written, the rest keep their contents
        if (resValid && resReady) begin
            vreg[resDest][resIdx] <= resData;
            popCount <= popCount + 1;
        end
    end
endmodule

//--- dv/testbench.sv
// self-checking bench for the vector shift unit with its register-file partner
// assumes the shift unit contract: one issue at a time, combinational source reads
`define VDS_CHECK(what, expv, gotv) begin \
    total_checks++; \
    if ((gotv) !== (expv)) begin \
        n_fail++; \
        $display("[ERR] %s expected %0h seen %0h", what, expv, gotv); \
    end \
end
module testbench
    import vds_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic issueValid = 1'b0;
    logic [INSTR_W-1:0] issueInstr = 16'h0000;
    logic [CNT_W-1:0] shiftCountIn = 24'h000000;
    logic [VL_W-1:0] vectorLengthIn = 7'h00;
    logic stallEn = 1'b0;
    logic issueTaken, unitBusy, srcRdEn, srcRelease, chainReady, destReady, resValid, resReady;
    logic [SEL_W-1:0] srcRdSel, resDest;
    logic [IDX_W-1:0] srcRdIdx, resIdx;
    logic [ELEM_W-1:0] srcRdData, resData;
    logic [ELEM_W-1:0] src [0:63];
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    vds_shift_unit #(.MAX_VL(64), .FIFO_DEPTH(8)) DUT (.clk(clk), .sys_rst(sys_rst),
        .issueValid(issueValid), .issueInstr(issueInstr), .shiftCountIn(shiftCountIn),
        .vectorLengthIn(vectorLengthIn), .issueTaken(issueTaken), .unitBusy(unitBusy),
        .srcRdEn(srcRdEn), .srcRdSel(srcRdSel), .srcRdIdx(srcRdIdx), .srcRdData(srcRdData),
        .srcRelease(srcRelease), .chainReady(chainReady), .destReady(destReady),
        .resValid(resValid), .resReady(resReady), .resDest(resDest), .resIdx(resIdx),
        .resData(resData));

    vds_vreg_model vreg (.clk(clk), .srcRdEn(srcRdEn), .srcRdSel(srcRdSel),
        .srcRdIdx(srcRdIdx), .srcRdData(srcRdData), .resValid(resValid),
        .resReady(resReady), .resDest(resDest), .resIdx(resIdx), .resData(resData),
        .stallEn(stallEn));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    function automatic logic [ELEM_W-1:0] exp_elem(input logic [6:0] op,
        input logic [CNT_W-1:0] cnt, input int n, input int vl);
        logic [WIDE_W-1:0] w;
        if (n >= vl) return 64'hA5A5_5A5A_C3C3_3C3C ^ 64'(n);
        case (op)
            OP_SHL_SINGLE: return (cnt > 24'h00003F) ? 64'h0 : src[n] << cnt;
            OP_SHR_SINGLE: return (cnt > 24'h00003F) ? 64'h0 : src[n] >> cnt;
            OP_SHL_DOUBLE: begin
                w = {src[n], (n + 1 < vl) ? src[n + 1] : 64'h0} << cnt;
                return w[WIDE_W-1:ELEM_W];
            end
            default: begin
                w = {(n > 0) ? src[n - 1] : 64'h0, src[n]} >> cnt;
                return w[ELEM_W-1:0];
            end
        endcase
    endfunction

    task automatic run_op(input logic [6:0] op, input logic [2:0] k, input logic [CNT_W-1:0] cnt,
        input int vl, input logic stall, input logic intrude);
        logic [CNT_W-1:0] effCnt;
        int c, nTaken, tTaken, tSrc, tChain, tDest, tIdle, pops;
        effCnt = (k == 3'h0) ? CNT_IMPLIED : cnt;
        for (int n = 0; n < 64; n++) begin
            src[n] = {32'(n) * 32'h9E37_79B9, 32'hF00D_0001 ^ 32'(n)};
            vreg.vreg[1][n] = src[n];
            vreg.vreg[2][n] = 64'hA5A5_5A5A_C3C3_3C3C ^ 64'(n);
            vreg.vreg[7][n] = 64'h0F0F_0F0F_0F0F_0F0F;
        end
        {nTaken, tTaken, tSrc, tChain, tDest, tIdle} = '0;
        // a stalled run must start its hold count afresh, so let one edge see no stall
        stallEn = 1'b0;
        @(negedge clk);
        stallEn = stall;
        pops = vreg.popCount;
        while (unitBusy !== 1'b0) @(negedge clk);
        issueValid = 1'b1;
        issueInstr = {op, 3'h2, 3'h1, k};
        shiftCountIn = cnt;
        vectorLengthIn = 7'(vl);
        @(negedge clk);
        issueValid = 1'b0;
        for (c = 1; c < 400; c++) begin
            if (issueTaken === 1'b1) begin
                nTaken++;
                tTaken = c;
            end
            if (srcRelease === 1'b1 && tSrc == 0) tSrc = c;
            if (chainReady === 1'b1 && tChain == 0) tChain = c;
            if (destReady === 1'b1 && tDest == 0) tDest = c;
            if (unitBusy === 1'b0 && tIdle == 0) tIdle = c;
            if (intrude && c == 3) begin
                issueValid = 1'b1;
                issueInstr = {OP_SHL_DOUBLE, 3'h7, 3'h1, 3'h0};
            end
            if (intrude && c == 4) issueValid = 1'b0;
            if (tIdle != 0 && resValid === 1'b0 && c > vl + 12) break;
            @(negedge clk);
        end
        `VDS_CHECK("issue pulses", 1, nTaken)
        `VDS_CHECK("issue cycle", ISSUE_CP, tTaken)
        `VDS_CHECK("chain cycle", CHAIN_CP, tChain)
        `VDS_CHECK("release cycle", (vl <= VL_SHORT_MAX) ? SRC_SHORT_CP : vl, tSrc)
        `VDS_CHECK("ready cycle", (vl <= 5) ? DEST_SHORT_CP : vl + DEST_ADD_CP, tDest)
        if (!stall) `VDS_CHECK("busy end", vl + BUSY_ADD_CP, tIdle)
        `VDS_CHECK("word count", vl, vreg.popCount - pops)
        for (int n = 0; n < 64; n++) begin
            `VDS_CHECK("dest element", exp_elem(op, effCnt, n, vl), vreg.vreg[2][n])
        end
        `VDS_CHECK("refused issue", 64'h0F0F_0F0F_0F0F_0F0F, vreg.vreg[7][0])
    endtask

    task automatic scen_left_double();
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h000003, 4, 1'b0, 1'b0);
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h000005, 1, 1'b0, 1'b0);
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h000040, 2, 1'b0, 1'b0);
    endtask

    task automatic scen_right_double();
        run_op(OP_SHR_DOUBLE, 3'h3, 24'h000003, 4, 1'b0, 1'b0);
        run_op(OP_SHR_DOUBLE, 3'h3, 24'h000046, 1, 1'b0, 1'b0);
    endtask

    task automatic scen_big_count();
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h000080, 3, 1'b0, 1'b0);
        run_op(OP_SHR_DOUBLE, 3'h3, 24'h000081, 3, 1'b0, 1'b0);
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h00007F, 3, 1'b0, 1'b0);
        run_op(OP_SHR_SINGLE, 3'h3, 24'h800001, 3, 1'b0, 1'b0);
    endtask

    task automatic scen_implied_count();
        run_op(OP_SHL_DOUBLE, 3'h0, 24'h000005, 3, 1'b0, 1'b0);
        run_op(OP_SHR_DOUBLE, 3'h0, 24'h000005, 3, 1'b0, 1'b0);
        run_op(OP_SHR_SINGLE, 3'h0, 24'h000005, 2, 1'b0, 1'b0);
    endtask

    task automatic scen_single();
        run_op(OP_SHL_SINGLE, 3'h3, 24'h00003F, 7, 1'b0, 1'b0);
        run_op(OP_SHR_SINGLE, 3'h3, 24'h000040, 6, 1'b0, 1'b0);
        run_op(OP_SHL_SINGLE, 3'h3, 24'h000004, 64, 1'b0, 1'b0);
    endtask

    task automatic scen_refused();
        int seen;
        seen = 0;
        issueValid = 1'b1;
        issueInstr = {7'h6C, 3'h7, 3'h1, 3'h3};
        vectorLengthIn = 7'h04;
        repeat (3) begin
            @(negedge clk);
            issueValid = 1'b0;
            if (issueTaken === 1'b1 || unitBusy === 1'b1) seen++;
        end
        `VDS_CHECK("unknown opcode", 0, seen)
        run_op(OP_SHR_DOUBLE, 3'h3, 24'h000009, 10, 1'b0, 1'b1);
    endtask

    task automatic scen_stall();
        // twenty results against a stalled sink: the buffer fills, refuses, then drains
        run_op(OP_SHL_DOUBLE, 3'h3, 24'h000011, 20, 1'b1, 1'b0);
        run_op(OP_SHR_DOUBLE, 3'h3, 24'h000021, 12, 1'b1, 1'b0);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        scen_refused();
        scen_left_double();
        scen_right_double();
        scen_big_count();
        scen_implied_count();
        scen_single();
        scen_stall();
        give_verdict();
    end
endmodule
